// ---- tb/uart_transmitter_bench.sv ----
`timescale 1ns/100ps
module uart_transmitter_bench;
  import utx_pkg::*;
  logic         ref_clk, rst_n, port_out, tx_irq_ack, serial_clock_pin_in, slv_run;
  logic         serial_out_pin, serial_out_override, serial_clock_pin_out, serial_clock_pin_oe_n;
  logic         buffer_empty_irq, tx_complete_irq, rx_par, rx_stop, par_en, stop2;
  utx_axi_req_t req;
  utx_axi_rsp_t rsp;
  logic [8:0]   rx_data;
  logic [15:0]  rx_count, period, nbits;
  logic [1:0]   resp;
  logic [31:0]  rdat;
  int           miscompares, cmp_count;
  logic [9:0]   frm_t [4] = '{10'h003, 10'h012, 10'h118, 10'h021};
  logic [8:0]   dat_t [4] = '{9'h0A5, 9'h0FF, 9'h03F, 9'h0C9};

  utx_top dut (.ref_clk, .rst_n, .axi_req(req), .axi_rsp(rsp), .port_out, .serial_out_pin, .serial_out_override,
    .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe_n, .tx_irq_ack, .buffer_empty_irq,
    .tx_complete_irq);
  utx_remote_rx peer (.ref_clk, .line(serial_out_pin), .listen(serial_out_override), .period, .nbits, .par_en,
    .stop2, .rx_data, .rx_par, .rx_stop, .rx_count);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // external serial clock for slave frames, 8 cycles a period, still otherwise
  initial begin
    serial_clock_pin_in = 1'b0;
    forever begin
      repeat (4) @(posedge ref_clk);
      serial_clock_pin_in <= slv_run && !serial_clock_pin_in;
    end
  end

  task automatic test_done();
    $display("miscompares %0d comparisons %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one bus transfer; ready and valid sampled mid-cycle, taken at next edge
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    logic aw, w, done, taw, tw, td;
    @(posedge ref_clk);
    aw = 1'b1;
    w = wr;
    done = 1'b0;
    req.awvalid <= wr;
    req.wvalid <= wr;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= wr;
    req.arvalid <= !wr;
    req.araddr <= a;
    req.rready <= !wr;
    while (!done) begin
      @(negedge ref_clk);
      taw = aw && (wr ? rsp.awready : rsp.arready);
      tw = w && rsp.wready;
      td = wr ? rsp.bvalid : rsp.rvalid;
      resp = wr ? rsp.bresp : rsp.rresp;
      rdat = rsp.rdata;
      @(posedge ref_clk);
      if (taw) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
        req.arvalid <= 1'b0;
      end
      if (tw) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
      if (td) begin
        done = 1'b1;
        req.bready <= 1'b0;
        req.rready <= 1'b0;
      end
    end
  endtask : xfer

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  task automatic wait_rx(input logic [15:0] n);
    int k;
    k = 0;
    while (rx_count < n && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    chk(32'(rx_count), 32'(n));
  endtask : wait_rx

  task automatic cfg(input logic [9:0] frm);
    nbits = (frm[2:0] == SIZE_NINE) ? 16'd9 : 16'(frm[2:0]) + 16'd5;
    period = !frm[FRM_SYNC] ? (frm[FRM_DSPD] ? 16'd16 : 16'd32) : (frm[FRM_MSTR] ? 16'd4 : 16'd8);
    par_en = frm[4];
    stop2 = frm[FRM_STOP2];
    xfer(1'b1, OFS_FRAME, 32'(frm));
  endtask : cfg

  task automatic frame(input logic [9:0] frm, input logic [8:0] d, input logic [15:0] n);
    logic [8:0] e;
    cfg(frm);
    e = d & 9'((1 << nbits) - 1);
    xfer(1'b1, OFS_STATUS, 32'h2);
    rd(OFS_STATUS, 32'h9);
    xfer(1'b1, OFS_DATA, 32'(d[7:0]));
    wait_rx(n);
    chk(32'(rx_data), 32'(e));
    if (par_en) chk(32'(rx_par), 32'(^e ^ frm[FRM_PAR]));
    chk(32'(rx_stop), 32'h1);
    repeat (period) @(posedge ref_clk);
    rd(OFS_STATUS, 32'hB);
  endtask : frame

  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end

  initial begin
    int k;
    rst_n = 1'b0;
    port_out = 1'b1;
    tx_irq_ack = 1'b0;
    slv_run = 1'b0;
    req = '0;
    miscompares = 0;
    cmp_count = 0;
    {period, nbits, par_en, stop2} = {16'd32, 16'd8, 2'b00};
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    port_out <= 1'b0;
    @(negedge ref_clk);
    chk(32'(serial_out_pin), 32'h0);
    rd(OFS_CTRL, 32'(RST_CTRL));
    rd(OFS_FRAME, 32'(RST_FRAME));
    rd(OFS_BAUD, 32'(RST_BAUD));
    rd(OFS_STATUS, 32'h1);
    xfer(1'b0, 5'h14, 32'h0);
    chk(32'(resp), 32'(RESP_ERR));
    xfer(1'b1, OFS_BAUD, 32'h1);
    chk(32'(resp), 32'(RESP_OK));
    xfer(1'b1, OFS_CTRL, 32'h3);
    @(negedge ref_clk);
    chk(32'(serial_out_pin), 32'h1);
    chk(32'(buffer_empty_irq), 32'h1);
    foreach (frm_t[i]) frame(frm_t[i], dat_t[i], 16'(i + 1));
    xfer(1'b1, OFS_CTRL, 32'hD);
    frame(10'h007, 9'h155, 16'd5);
    @(negedge ref_clk);
    chk(32'(tx_complete_irq), 32'h1);
    chk(32'(buffer_empty_irq), 32'h0);
    @(posedge ref_clk);
    tx_irq_ack <= 1'b1;
    @(posedge ref_clk);
    tx_irq_ack <= 1'b0;
    @(negedge ref_clk);
    chk(32'(tx_complete_irq), 32'h0);
    cfg(10'h003);
    xfer(1'b1, OFS_CTRL, 32'h3);
    xfer(1'b1, OFS_DATA, 32'h11);
    xfer(1'b1, OFS_DATA, 32'h22);
    @(negedge ref_clk);
    chk(32'(buffer_empty_irq), 32'h0);
    rd(OFS_STATUS, 32'hC);
    xfer(1'b1, OFS_CTRL, 32'h0);
    @(negedge ref_clk);
    chk(32'(serial_out_override), 32'h1);
    wait_rx(16'd6);
    chk(32'(rx_data), 32'h11);
    wait_rx(16'd7);
    chk(32'(rx_data), 32'h22);
    k = 0;
    while (serial_out_override !== 1'b0 && k < 100) begin
      @(negedge ref_clk);
      k++;
    end
    chk(32'(serial_out_override), 32'h0);
    chk(32'(serial_out_pin), 32'h0);
    cfg(10'h240);
    xfer(1'b1, OFS_CTRL, 32'h1);
    @(negedge ref_clk);
    chk(32'(serial_clock_pin_oe_n), 32'h0);
    // one baud tick every two cycles, so the clock flips once in two cycles
    k = int'(serial_clock_pin_out);
    repeat (2) @(negedge ref_clk);
    chk(32'(serial_clock_pin_out) ^ 32'(k), 32'h1);
    frame(10'h240, 9'h0B3, 16'd8);
    frame(10'h2C2, 9'h04E, 16'd9);
    slv_run <= 1'b1;
    frame(10'h043, 9'h0D2, 16'd10);
    slv_run <= 1'b0;
    chk(32'(serial_clock_pin_oe_n), 32'h1);
    test_done();
  end
endmodule : uart_transmitter_bench

// ---- tb/utx_remote_rx.sv ----
`timescale 1ns/100ps
module utx_remote_rx (
  // clock and line
  input  wire logic        ref_clk,
  input  wire logic        line,
  input  wire logic        listen,
  // expected frame format
  input  wire logic [15:0] period,
  input  wire logic [15:0] nbits,
  input  wire logic        par_en,
  input  wire logic        stop2,
  // captured frame
  output logic      [8:0]  rx_data,
  output logic             rx_par,
  output logic             rx_stop,
  output logic      [15:0] rx_count
);
  initial begin
    rx_data = 9'h000;
    rx_par = 1'b0;
    rx_stop = 1'b0;
    rx_count = 16'h0000;
    forever begin
      @(negedge line);
      repeat (period / 2) @(posedge ref_clk);
      // a port-driven low is not a start bit
      if (listen && line === 1'b0) begin
        rx_data = 9'h000;
        for (int i = 0; i < nbits; i++) begin
          repeat (period) @(posedge ref_clk);
          rx_data[i] = line;
        end
        if (par_en) begin
          repeat (period) @(posedge ref_clk);
          rx_par = line;
        end
        repeat (period) @(posedge ref_clk);
        rx_stop = line;
        if (stop2) begin
          repeat (period) @(posedge ref_clk);
          rx_stop = rx_stop & line;
        end
        rx_count = rx_count + 16'h0001;
      end
    end
  end
endmodule : utx_remote_rx

// ---- verilog/utx_baud.sv ----
`timescale 1ns/100ps
module utx_baud #(
  parameter int unsigned W = 12
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // divisor
  input  wire logic [W-1:0] div,
  input  wire logic         load,
  // tick
  output logic              tick
);
  import utx_pkg::*;
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } utx_baud_st_t;
  utx_baud_st_t r;
  utx_baud_st_t next_r;

  if (W < 2 || W > 16) begin : g_chk
    $error("utx_baud: divisor width out of range");
  end

  always_comb begin
    next_r = r;
    next_r.tick = (r.cnt == '0) && !load;
    if (load || r.cnt == '0) begin
      next_r.cnt = div;
    end else begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_reload_value: assert property (load |=> r.cnt == $past(div))
    else $error("divisor not reloaded");
  a_tick_spacing: assert property (tick && div != '0 && !load |=> !tick)
    else $error("ticks too close");
endmodule : utx_baud

// ---- verilog/utx_edge.sv ----
`timescale 1ns/100ps
module utx_edge (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // serial clock in
  input  wire logic pin_in,
  // edges
  output logic      rise,
  output logic      fall
);
  import utx_pkg::*;
  typedef struct packed {
    logic [2:0] sh;
    logic       rise;
    logic       fall;
  } utx_edge_st_t;
  utx_edge_st_t r;
  utx_edge_st_t next_r;

  always_comb begin
    next_r = r;
    next_r.sh = {r.sh[1:0], pin_in};
    next_r.rise = r.sh[1] && !r.sh[2];
    next_r.fall = !r.sh[1] && r.sh[2];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rise = r.rise;
  assign fall = r.fall;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_edge_single: assert property (rise |=> !rise)
    else $error("rising edge pulse too long");
  a_edge_exclusive: assert property (!(rise && fall))
    else $error("both edges at once");
endmodule : utx_edge

// ---- verilog/utx_pkg.sv ----
// Summary of operation
// - enable hands serial output pin to transmitter
// - sync master mode takes over serial clock pin
// - data register write loads buffer, starts sending
// - buffer moves to idle or just-finished shifter
// - shifter sends frame at selected bit rate
// - unused upper data bits ignored below eight
// - empty flag follows transmit buffer occupancy
// - data register write clears empty flag
// - empty request held while flag and enable
// - complete flag sets after frame, buffer empty
// - service acknowledge or written one clears complete
// - complete request raised when flag and enable
// - parity enable inserts parity before stop bits
// - disable waits until shifter and buffer empty
// - disabled transmitter returns pin to port
// - start low, data lsb first, parity, stops high
// - parity is data xor, inverted when odd
// - divisor plus one ticks, divided 16, 8, 2
// - polarity selects serial clock change edge
package utx_pkg;
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned BAUD_W     = 12;
  localparam logic [4:0]  OFS_STATUS = 5'h00;
  localparam logic [4:0]  OFS_CTRL   = 5'h04;
  localparam logic [4:0]  OFS_FRAME  = 5'h08;
  localparam logic [4:0]  OFS_BAUD   = 5'h0C;
  localparam logic [4:0]  OFS_DATA   = 5'h10;
  localparam int unsigned STA_EMPTY  = 0;
  localparam int unsigned STA_TXC    = 1;
  localparam int unsigned STA_BUSY   = 2;
  localparam int unsigned STA_ACTIVE = 3;
  localparam int unsigned CTL_EN     = 0;
  localparam int unsigned CTL_BEIE   = 1;
  localparam int unsigned CTL_TCIE   = 2;
  localparam int unsigned CTL_NINTH  = 3;
  localparam int unsigned FRM_SIZE   = 0;
  localparam int unsigned FRM_PAR    = 3;
  localparam int unsigned FRM_STOP2  = 5;
  localparam int unsigned FRM_SYNC   = 6;
  localparam int unsigned FRM_POL    = 7;
  localparam int unsigned FRM_DSPD   = 8;
  localparam int unsigned FRM_MSTR   = 9;
  localparam logic [3:0]  RST_CTRL   = 4'h0;
  localparam logic [9:0]  RST_FRAME  = 10'h003;
  localparam logic [11:0] RST_BAUD   = 12'h000;
  localparam logic [3:0]  DIV_NORMAL = 4'hF;
  localparam logic [3:0]  DIV_DOUBLE = 4'h7;
  localparam logic [2:0]  SIZE_NINE  = 3'h7;
  localparam logic [1:0]  RESP_OK    = 2'h0;
  localparam logic [1:0]  RESP_ERR   = 2'h2;

  typedef enum logic [5:0] {
    UTX_IDLE  = 6'h01,
    UTX_WAIT  = 6'h02,
    UTX_START = 6'h04,
    UTX_DATA  = 6'h08,
    UTX_PAR   = 6'h10,
    UTX_STOP  = 6'h20
  } utx_state_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } utx_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } utx_axi_rsp_t;
endpackage : utx_pkg

// ---- verilog/utx_top.sv ----
`timescale 1ns/100ps
module utx_top (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // register bus
  input  wire utx_pkg::utx_axi_req_t axi_req,
  output utx_pkg::utx_axi_rsp_t      axi_rsp,
  // serial output pin
  input  wire logic                  port_out,
  output logic                       serial_out_pin,
  output logic                       serial_out_override,
  // serial clock pin
  input  wire logic                  serial_clock_pin_in,
  output logic                       serial_clock_pin_out,
  output logic                       serial_clock_pin_oe_n,
  // interrupt requests
  input  wire logic                  tx_irq_ack,
  output logic                       buffer_empty_irq,
  output logic                       tx_complete_irq
);
  import utx_pkg::*;

  typedef struct packed {
    utx_state_t        st;
    logic [3:0]        ctl;
    logic [9:0]        frm;
    logic [11:0]       baud;
    logic              baud_load;
    logic [8:0]        buf_d;
    logic              buf_full;
    logic [8:0]        shf;
    logic [3:0]        cnt;
    logic              par;
    logic              line;
    logic              tx_complete_flag;
    logic              active;
    logic [3:0]        pre;
    logic              xck;
    logic              aw_ok;
    logic [ADDR_W-1:0] awa;
    logic              w_ok;
    logic [31:0]       wd;
    logic [3:0]        ws;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } utx_regs_t;

  utx_regs_t   r;
  utx_regs_t   next_r;
  logic        tick;
  logic        xrise;
  logic        xfall;
  logic        wr_go;
  logic        dwr;
  logic        strobe;
  logic        txc_set;
  logic        frame_end;
  logic [31:0] rd;
  logic [1:0]  rresp;

  utx_baud #(
    .W (BAUD_W)
  ) u_baud (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .div     (r.baud),
    .load    (r.baud_load),
    .tick    (tick)
  );

  utx_edge u_edge (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  (serial_clock_pin_in),
    .rise    (xrise),
    .fall    (xfall)
  );

  // data bits per character
  function automatic logic [3:0] nbits(input logic [2:0] size);
    logic [3:0] n;
    n = 4'h8;
    if (size == SIZE_NINE) begin
      n = 4'h9;
    end else if (size < 3'h4) begin
      n = {2'h0, size[1:0]} + 4'h5;
    end
    return n;
  endfunction : nbits

  // clear bits above the character size
  function automatic logic [8:0] mask9(input logic [8:0] d, input logic [2:0] size);
    logic [8:0] m;
    m = 9'h1FF >> (4'h9 - nbits(size));
    return d & m;
  endfunction : mask9

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : wmerge

  always_comb begin
    next_r = r;
    next_r.baud_load = 1'b0;
    wr_go = 1'b0;
    dwr = 1'b0;
    strobe = 1'b0;
    txc_set = 1'b0;
    frame_end = 1'b0;
    rd = 32'h0;
    rresp = RESP_OK;

    // write channel capture, either order
    if (axi_req.awvalid && !r.aw_ok) begin
      next_r.aw_ok = 1'b1;
      next_r.awa = axi_req.awaddr;
    end
    if (axi_req.wvalid && !r.w_ok) begin
      next_r.w_ok = 1'b1;
      next_r.wd = axi_req.wdata;
      next_r.ws = axi_req.wstrb;
    end
    if (r.bvalid && axi_req.bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_ok && r.w_ok && !r.bvalid) begin
      wr_go = 1'b1;
      next_r.aw_ok = 1'b0;
      next_r.w_ok = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OK;
      case (r.awa)
        OFS_STATUS: begin
          if (r.ws[0] && r.wd[STA_TXC]) begin
            next_r.tx_complete_flag = 1'b0;
          end
        end
        OFS_CTRL: begin
          next_r.ctl = 4'(wmerge({28'h0, r.ctl}, r.wd, r.ws));
        end
        OFS_FRAME: begin
          next_r.frm = 10'(wmerge({22'h0, r.frm}, r.wd, r.ws));
        end
        OFS_BAUD: begin
          next_r.baud = 12'(wmerge({20'h0, r.baud}, r.wd, r.ws));
          next_r.baud_load = 1'b1;
        end
        OFS_DATA: begin
          dwr = r.ws[0];
        end
        default: begin
          next_r.bresp = RESP_ERR;
        end
      endcase
    end

    // read channel
    case (axi_req.araddr)
      OFS_STATUS: begin
        rd[STA_EMPTY] = !r.buf_full;
        rd[STA_TXC] = r.tx_complete_flag;
        rd[STA_BUSY] = r.st != UTX_IDLE;
        rd[STA_ACTIVE] = r.active;
      end
      OFS_CTRL: begin
        rd = {28'h0, r.ctl};
      end
      OFS_FRAME: begin
        rd = {22'h0, r.frm};
      end
      OFS_BAUD: begin
        rd = {20'h0, r.baud};
      end
      OFS_DATA: begin
        rd = {23'h0, r.buf_d};
      end
      default: begin
        rresp = RESP_ERR;
      end
    endcase
    if (r.rvalid && axi_req.rready) begin
      next_r.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd;
      next_r.rresp = rresp;
    end

    // acknowledge before any set, so a set wins
    if (tx_irq_ack) begin
      next_r.tx_complete_flag = 1'b0;
    end

    // stays on while anything is left to send
    if (r.ctl[CTL_EN]) begin
      next_r.active = 1'b1;
    end else if (!r.buf_full && r.st == UTX_IDLE && !dwr) begin
      next_r.active = 1'b0;
    end

    // bit strobe per mode
    if (r.active) begin
      if (!r.frm[FRM_SYNC]) begin
        if (tick) begin
          if (r.pre == (r.frm[FRM_DSPD] ? DIV_DOUBLE : DIV_NORMAL)) begin
            next_r.pre = 4'h0;
            strobe = 1'b1;
          end else begin
            next_r.pre = r.pre + 4'h1;
          end
        end
      end else if (r.frm[FRM_MSTR]) begin
        if (tick) begin
          next_r.xck = !r.xck;
          strobe = r.xck == r.frm[FRM_POL];
        end
      end else begin
        strobe = r.frm[FRM_POL] ? xfall : xrise;
      end
    end

    unique case (r.st)
      UTX_IDLE: begin
        next_r.line = 1'b1;
        if (r.active && r.buf_full) begin
          next_r.shf = r.buf_d;
          next_r.par = ^r.buf_d ^ r.frm[FRM_PAR];
          next_r.buf_full = 1'b0;
          next_r.st = UTX_WAIT;
        end
      end
      UTX_WAIT: begin
        if (strobe) begin
          next_r.line = 1'b0;
          next_r.st = UTX_START;
        end
      end
      UTX_START: begin
        if (strobe) begin
          next_r.line = r.shf[0];
          next_r.shf = r.shf >> 1;
          next_r.cnt = 4'h1;
          next_r.st = UTX_DATA;
        end
      end
      UTX_DATA: begin
        if (strobe) begin
          next_r.cnt = 4'h0;
          if (r.cnt != nbits(r.frm[FRM_SIZE +: 3])) begin
            next_r.line = r.shf[0];
            next_r.shf = r.shf >> 1;
            next_r.cnt = r.cnt + 4'h1;
          end else if (r.frm[FRM_PAR + 1]) begin
            next_r.line = r.par;
            next_r.st = UTX_PAR;
          end else begin
            next_r.line = 1'b1;
            next_r.st = UTX_STOP;
          end
        end
      end
      UTX_PAR: begin
        if (strobe) begin
          next_r.line = 1'b1;
          next_r.st = UTX_STOP;
        end
      end
      UTX_STOP: begin
        if (strobe) begin
          if (r.cnt == 4'h0 && r.frm[FRM_STOP2]) begin
            next_r.cnt = 4'h1;
          end else begin
            frame_end = 1'b1;
            if (r.buf_full) begin
              next_r.shf = r.buf_d;
              next_r.par = ^r.buf_d ^ r.frm[FRM_PAR];
              next_r.buf_full = 1'b0;
              next_r.line = 1'b0;
              next_r.st = UTX_START;
            end else begin
              txc_set = 1'b1;
              next_r.tx_complete_flag = 1'b1;
              next_r.st = UTX_IDLE;
            end
          end
        end
      end
    endcase

    // load after the handoff so a same-cycle write is kept
    if (dwr) begin
      next_r.buf_d = mask9({r.ctl[CTL_NINTH], r.wd[7:0]}, r.frm[FRM_SIZE +: 3]);
      next_r.buf_full = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= UTX_IDLE;
      r.ctl <= RST_CTRL;
      r.frm <= RST_FRAME;
      r.baud <= RST_BAUD;
      r.line <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign axi_rsp.awready = !r.aw_ok;
  assign axi_rsp.wready = !r.w_ok;
  assign axi_rsp.bvalid = r.bvalid;
  assign axi_rsp.bresp = r.bresp;
  assign axi_rsp.arready = !r.rvalid;
  assign axi_rsp.rvalid = r.rvalid;
  assign axi_rsp.rdata = r.rdata;
  assign axi_rsp.rresp = r.rresp;

  assign serial_out_override = r.active;
  assign serial_out_pin = r.active ? r.line : port_out;
  assign serial_clock_pin_out = r.xck;
  assign serial_clock_pin_oe_n = !(r.active && r.frm[FRM_SYNC] && r.frm[FRM_MSTR]);
  assign buffer_empty_irq = !r.buf_full && r.ctl[CTL_BEIE];
  assign tx_complete_irq = r.tx_complete_flag && r.ctl[CTL_TCIE];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_frame_done;
    frame_end;
  endsequence
  sequence s_no_pending;
    !r.buf_full;
  endsequence
  sequence s_pending;
    r.buf_full;
  endsequence

  a_pin_takeover: assert property (r.ctl[CTL_EN] |=> serial_out_override)
    else $error("serial output not taken over");
  a_clk_takeover: assert property (r.active && r.frm[FRM_SYNC] && r.frm[FRM_MSTR]
                                   |-> !serial_clock_pin_oe_n)
    else $error("serial clock not driven");
  a_clk_toggle: assert property (r.active && r.frm[FRM_SYNC] && r.frm[FRM_MSTR] && tick
                                 |=> serial_clock_pin_out != $past(serial_clock_pin_out))
    else $error("serial clock did not toggle on tick");
  a_master_edge: assert property (r.active && r.frm[FRM_SYNC] && r.frm[FRM_MSTR] && strobe
                                  |=> serial_clock_pin_out != $past(r.frm[FRM_POL]))
    else $error("data changed on wrong clock edge");
  a_write_fills: assert property (dwr |=> !axi_rsp.bvalid || r.buf_full || r.st == UTX_WAIT)
    else $error("data write did not fill buffer");
  a_idle_handoff: assert property (r.st == UTX_IDLE && r.active && r.buf_full && !dwr
                                   |=> r.st == UTX_WAIT && !r.buf_full)
    else $error("idle shifter not loaded");
  a_back_to_back: assert property (s_frame_done ##0 s_pending |=> r.st == UTX_START && !r.line)
    else $error("pending data not sent after stop");
  a_txc_at_end: assert property (s_frame_done ##0 s_no_pending |=> r.tx_complete_flag)
    else $error("complete flag not set");
  a_txc_ack: assert property (tx_irq_ack && !txc_set |=> !r.tx_complete_flag)
    else $error("acknowledge did not clear flag");
  a_txc_irq: assert property ($rose(r.tx_complete_flag) && r.ctl[CTL_TCIE] |-> tx_complete_irq)
    else $error("complete request missing");
  a_empty_irq: assert property (s_no_pending ##1 (s_no_pending and r.ctl[CTL_BEIE])
                                |-> buffer_empty_irq)
    else $error("empty request missing");
  a_start_low: assert property (r.st == UTX_START |-> !serial_out_pin)
    else $error("start bit not low");
  a_lsb_first: assert property (r.st == UTX_START && strobe |=> serial_out_pin == $past(r.shf[0]))
    else $error("first data bit not lsb");
  a_stop_high: assert property (r.st == UTX_STOP |-> serial_out_pin)
    else $error("stop bit not high");
  a_parity_slot: assert property (r.st == UTX_PAR |-> r.frm[FRM_PAR + 1] && serial_out_pin == r.par)
    else $error("parity bit wrong");
  a_parity_value: assert property (r.st == UTX_WAIT |-> r.par == (^r.shf ^ r.frm[FRM_PAR]))
    else $error("parity computed wrong");
  a_size_mask: assert property (r.st == UTX_WAIT |-> r.shf == mask9(r.shf, r.frm[FRM_SIZE +: 3]))
    else $error("unused data bits not cleared");
  a_disable_hold: assert property (r.active && !r.ctl[CTL_EN] && (r.st != UTX_IDLE || r.buf_full)
                                   |=> r.active)
    else $error("transmitter stopped early");
  a_port_return: assert property (!r.active |-> serial_out_pin == port_out && r.st == UTX_IDLE)
    else $error("pin not returned to port");
endmodule : utx_top
